/* logic/ucs_status.sv */
/*
 * Line-status flag logic for one serial channel with an APB register slave.
 * Holds receive error tracking, break handling, transmit empty/ready flags
 * and the status register. Receiver and transmitter sit outside on the
 * same clock and report events as one-cycle strobes; the receive line
 * itself arrives asynchronously and is resynchronised here.
 */
`timescale 1ns/100ps
module ucs_status
   import ucs_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata_ff,
   output logic                   pready_ff,
   output logic                   pslverr_ff,
   // Receiver events
   input  wire logic              serial_rx_input,
   input  wire logic              bit_clk_en,
   input  wire logic              rx_char_done,
   input  wire logic [DATA_W-1:0] rx_char_data,
   input  wire logic              rx_stop_bit,
   input  wire logic              rx_parity_ok,
   input  wire logic              rx_ad_bit,
   // Transmitter events
   input  wire logic              tx_char_moved,
   input  wire logic              tx_stop_sent,
   output logic                   tx_load_ff,
   output logic      [DATA_W-1:0] tx_data_ff,
   output logic                   tx_active_ff,
   // Break change event
   output logic                   break_change_ff
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic              rx_sync1_ff, rx_line_ff;
   logic [CT_W-1:0]   ctrl_ff, nxt_ctrl;
   logic [31:0]       nxt_prdata;
   logic              nxt_pready, nxt_pslverr;
   logic              acc_wr, acc_rd, setup;
   logic              cmd_err, cmd_rx, cmd_tx, rx_pop, host_load;
   logic              inhibit_ff, nxt_inhibit;
   logic [1:0]        mark_ff, nxt_mark;
   logic              nxt_brk_chg;
   logic              ovr_ff, nxt_ovr;
   logic [FL_W-1:0]   acc_ff, nxt_acc;
   logic [CNT_W-1:0]  txc_ff, nxt_txc;
   logic              txe_ff, nxt_txe, txr_ff, nxt_txr, nxt_active;
   logic              nxt_load;
   logic [DATA_W-1:0] nxt_txd;
   logic              is_break, push;
   logic [FL_W-1:0]   char_flags;
   logic [DATA_W-1:0] head_data;
   logic [FL_W-1:0]   head_flags, entered_flags;
   logic [CNT_W-1:0]  rx_cnt;
   logic              hold_vld, fifo_ovr, entered;
   logic [7:0]        status;

   // Register index match for an aligned word
   function automatic logic reg_hit(input logic [7:0] a, input logic [5:0] idx);
      reg_hit = (a[7:2] == idx) && (a[1:0] == 2'h0);
   endfunction : reg_hit

   ////////////////////////////////////////////////////////////////////////
   // Receive line synchroniser; only the second stage is read
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_sync1_ff <= 1'b1;
         rx_line_ff  <= 1'b1;
      end
      else
      begin
         rx_sync1_ff <= serial_rx_input;
         rx_line_ff  <= rx_sync1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait state, write and read effects at the access edge
   assign setup     = psel && !penable;
   assign acc_wr    = psel && penable && pready_ff && pwrite;
   assign acc_rd    = psel && penable && pready_ff && !pwrite;
   assign cmd_err   = acc_wr && reg_hit(paddr, IDX_CMD) && (pwdata[3:0] == CMD_RST_ERR);
   assign cmd_rx    = acc_wr && reg_hit(paddr, IDX_CMD) && (pwdata[3:0] == CMD_RST_RX);
   assign cmd_tx    = acc_wr && reg_hit(paddr, IDX_CMD) && (pwdata[3:0] == CMD_RST_TX);
   assign rx_pop    = acc_rd && reg_hit(paddr, IDX_DATA);
   // Loads while not ready are lost, as on the real line
   assign host_load = acc_wr && reg_hit(paddr, IDX_DATA) && txr_ff;

   // Read data is prepared in the setup cycle so it comes from a flop
   always_comb
   begin
      nxt_pready  = setup;
      nxt_pslverr = setup && !(reg_hit(paddr, IDX_DATA) || reg_hit(paddr, IDX_STATUS) ||
                               reg_hit(paddr, IDX_CTRL) || reg_hit(paddr, IDX_CMD));
      nxt_prdata  = '0;
      if (setup && !pwrite)
      begin
         if (reg_hit(paddr, IDX_DATA))
            nxt_prdata = {24'h000000, head_data};
         else if (reg_hit(paddr, IDX_STATUS))
            nxt_prdata = {24'h000000, status};
         else if (reg_hit(paddr, IDX_CTRL))
            nxt_prdata = {28'h0000000, ctrl_ff};
      end
      nxt_ctrl = ctrl_ff;
      if (acc_wr && reg_hit(paddr, IDX_CTRL))
         nxt_ctrl = pwdata[CT_W-1:0];
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata_ff  <= '0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         ctrl_ff    <= CTRL_RESET;
      end
      else
      begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         ctrl_ff    <= nxt_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Character flags; the receiver only flags all-zero once the whole frame
   // time has been spacing, so a mid-character break shows one char later
   assign is_break  = (rx_char_data == '0) && !rx_stop_bit;
   assign char_flags[FL_BREAK]  = is_break;
   assign char_flags[FL_FRAME]  = !rx_stop_bit;
   assign char_flags[FL_PARITY] = ctrl_ff[CT_MDROP] ? rx_ad_bit
                                : ctrl_ff[CT_PARITY] && !rx_parity_ok;
   assign push = rx_char_done && !inhibit_ff;

   ucs_rx_fifo u_rx_fifo
   (
      .core_clk      (core_clk),
      .arst_n        (arst_n),
      .flush         (cmd_rx),
      .clr_flags     (cmd_err),
      .push          (push),
      .push_data     (rx_char_data),
      .push_flags    (char_flags),
      .pop           (rx_pop),
      .head_data     (head_data),
      .head_flags    (head_flags),
      .count         (rx_cnt),
      .hold_vld      (hold_vld),
      .overrun       (fifo_ovr),
      .entered       (entered),
      .entered_flags (entered_flags)
   );

   ////////////////////////////////////////////////////////////////////////
   // Break inhibit, overrun and block-mode accumulator; sets beat clears
   always_comb
   begin
      nxt_inhibit = inhibit_ff;
      nxt_mark    = mark_ff;
      nxt_brk_chg = 1'b0;
      if (inhibit_ff && bit_clk_en)
         nxt_mark = rx_line_ff ? mark_ff + 2'h1 : 2'h0;
      if (inhibit_ff && nxt_mark == MARK_EDGES)
      begin
         nxt_inhibit = 1'b0;
         nxt_mark    = 2'h0;
         nxt_brk_chg = 1'b1;
      end
      if (push && is_break)
      begin
         nxt_inhibit = 1'b1;
         nxt_mark    = 2'h0;
         nxt_brk_chg = 1'b1;
      end
      nxt_ovr = (ovr_ff && !cmd_err) || fifo_ovr;
      nxt_acc = (cmd_err || cmd_rx) ? '0 : acc_ff;
      if (entered)
         nxt_acc = nxt_acc | entered_flags;
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         inhibit_ff      <= 1'b0;
         mark_ff         <= 2'h0;
         break_change_ff <= 1'b0;
         ovr_ff          <= 1'b0;
         acc_ff          <= '0;
      end
      else
      begin
         inhibit_ff      <= nxt_inhibit;
         mark_ff         <= nxt_mark;
         break_change_ff <= nxt_brk_chg;
         ovr_ff          <= nxt_ovr;
         acc_ff          <= nxt_acc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit side: occupancy, empty and ready, delayed disable
   always_comb
   begin
      nxt_txc    = txc_ff;
      nxt_txe    = txe_ff;
      nxt_active = tx_active_ff;
      nxt_load   = host_load;
      nxt_txd    = host_load ? pwdata[DATA_W-1:0] : tx_data_ff;
      if (tx_char_moved && txc_ff != '0)
         nxt_txc = nxt_txc - 4'h1;
      if (host_load)
      begin
         nxt_txc = nxt_txc + 4'h1;
         nxt_txe = 1'b0;
      end
      else if (tx_stop_sent && txc_ff == '0 && !tx_char_moved)
         nxt_txe = 1'b1;
      if (ctrl_ff[CT_TXEN] && !tx_active_ff)
      begin
         nxt_active = 1'b1;
         nxt_txe    = 1'b1;
      end
      else if (!ctrl_ff[CT_TXEN] && tx_active_ff && (txe_ff || nxt_txe))
      begin
         // Disable waits for the line to drain, then takes effect
         nxt_active = 1'b0;
         nxt_txe    = 1'b0;
         nxt_txc    = '0;
      end
      if (cmd_tx)
      begin
         nxt_active = 1'b0;
         nxt_txe    = 1'b0;
         nxt_txc    = '0;
         nxt_load   = 1'b0;
      end
      nxt_txr = nxt_active && (nxt_txc != TX_FULL_CNT);
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         txc_ff       <= '0;
         txe_ff       <= 1'b0;
         txr_ff       <= 1'b0;
         tx_active_ff <= 1'b0;
         tx_load_ff   <= 1'b0;
         tx_data_ff   <= '0;
      end
      else
      begin
         txc_ff       <= nxt_txc;
         txe_ff       <= nxt_txe;
         txr_ff       <= nxt_txr;
         tx_active_ff <= nxt_active;
         tx_load_ff   <= nxt_load;
         tx_data_ff   <= nxt_txd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status image: head flags or block accumulator above the live bits
   always_comb
   begin
      status[ST_BREAK:ST_PARITY] = ctrl_ff[CT_BLOCK] ? acc_ff
                                 : (rx_cnt != '0 ? head_flags : '0);
      status[ST_OVERRUN] = ovr_ff;
      status[ST_TXEMPTY] = txe_ff;
      status[ST_TXREADY] = txr_ff;
      status[ST_RXFULL]  = (rx_cnt == RX_FULL_CNT);
      status[ST_RXREADY] = (rx_cnt != '0);
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Break entry, and the change pulse with inhibit that must follow it
   sequence s_break_entry;
      push && is_break;
   endsequence
   sequence s_break_flagged;
      break_change_ff && inhibit_ff;
   endsequence

   a_break_change: assert property (@(posedge core_clk) disable iff (!arst_n)
      s_break_entry |=> s_break_flagged)
      else $error("break entry did not raise change event");
   a_break_inhibit: assert property (@(posedge core_clk) disable iff (!arst_n)
      inhibit_ff && !$past(rx_line_ff) |-> mark_ff <= 2'h1)
      else $error("break released without marking");
   a_break_release: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(inhibit_ff) && !$past(cmd_rx) |-> $past(rx_line_ff) && break_change_ff)
      else $error("break end not signalled");
   a_ovr_set: assert property (@(posedge core_clk) disable iff (!arst_n)
      fifo_ovr |=> ovr_ff && hold_vld)
      else $error("overrun not flagged");
   a_ovr_clear_only: assert property (@(posedge core_clk) disable iff (!arst_n)
      $fell(ovr_ff) |-> $past(cmd_err))
      else $error("overrun cleared without command");
   a_err_cmd_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
      cmd_err && !entered |=> acc_ff == '0 && (rx_cnt == '0 || head_flags == '0))
      else $error("error flags survived reset command");
   a_txe_enable: assert property (@(posedge core_clk) disable iff (!arst_n)
      ctrl_ff[CT_TXEN] && !tx_active_ff && !cmd_tx |=> txe_ff && txr_ff ##1 tx_active_ff)
      else $error("enable did not set empty and ready");
   a_txe_load_clr: assert property (@(posedge core_clk) disable iff (!arst_n)
      host_load |=> !txe_ff && tx_load_ff)
      else $error("host load did not clear empty");
   a_txr_full: assert property (@(posedge core_clk) disable iff (!arst_n)
      txc_ff == TX_FULL_CNT |-> !txr_ff)
      else $error("ready while transmit FIFO full");
   a_rx_full_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
      rx_pop && hold_vld && !cmd_rx |=> rx_cnt == RX_FULL_CNT)
      else $error("full dropped while a character was held");
endmodule : ucs_status

/* inc/ucs_pkg.sv */
/*
 * Constants for the channel line-status flag block: register map, field
 * positions, command codes, mode bits and FIFO sizes.
 * Assumes a single 40 MHz core clock and an APB master with 32-bit data.
 */
package ucs_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_DATA   = 6'h00;
   localparam logic [5:0] IDX_STATUS = 6'h01;
   localparam logic [5:0] IDX_CTRL   = 6'h02;
   localparam logic [5:0] IDX_CMD    = 6'h03;

   // Status bit positions
   localparam int ST_BREAK   = 7;
   localparam int ST_FRAME   = 6;
   localparam int ST_PARITY  = 5;
   localparam int ST_OVERRUN = 4;
   localparam int ST_TXEMPTY = 3;
   localparam int ST_TXREADY = 2;
   localparam int ST_RXFULL  = 1;
   localparam int ST_RXREADY = 0;

   // Per-character flag positions inside a FIFO entry
   localparam int FL_BREAK  = 2;
   localparam int FL_FRAME  = 1;
   localparam int FL_PARITY = 0;
   localparam int FL_W      = 3;

   // Control register fields
   localparam int CT_TXEN   = 0;
   localparam int CT_BLOCK  = 1;
   localparam int CT_PARITY = 2;
   localparam int CT_MDROP  = 3;
   localparam int CT_W      = 4;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // Command codes in the low nibble of the command register
   localparam logic [3:0] CMD_RST_RX  = 4'h2;
   localparam logic [3:0] CMD_RST_TX  = 4'h3;
   localparam logic [3:0] CMD_RST_ERR = 4'h4;

   // FIFO sizes and data width
   localparam int DATA_W   = 8;
   localparam int RX_DEPTH = 8;
   localparam int TX_DEPTH = 8;
   localparam int CNT_W    = 4;
   localparam logic [CNT_W-1:0] RX_FULL_CNT = 4'h8;
   localparam logic [CNT_W-1:0] TX_FULL_CNT = 4'h8;

   // Marking samples on the 1x rate needed to end a break
   localparam logic [1:0] MARK_EDGES = 2'h2;
endpackage : ucs_pkg

/* logic/ucs_rx_fifo.sv */
/*
 * Receive FIFO with a one-character holding stage standing for the receive
 * shift register. Each entry keeps data and its three error flags.
 * Assumes push and pop are single-cycle strobes on the core clock.
 */
`timescale 1ns/100ps
module ucs_rx_fifo
   import ucs_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // Control
   input  wire logic              flush,
   input  wire logic              clr_flags,
   // Write side
   input  wire logic              push,
   input  wire logic [DATA_W-1:0] push_data,
   input  wire logic [FL_W-1:0]   push_flags,
   // Read side
   input  wire logic              pop,
   output logic      [DATA_W-1:0] head_data,
   output logic      [FL_W-1:0]   head_flags,
   // State
   output logic      [CNT_W-1:0]  count,
   output logic                   hold_vld,
   output logic                   overrun,
   output logic                   entered,
   output logic      [FL_W-1:0]   entered_flags
);
   logic [DATA_W+FL_W-1:0] mem_ff [RX_DEPTH];
   logic [DATA_W+FL_W-1:0] nxt_mem [RX_DEPTH];
   logic [2:0]             rp_ff, nxt_rp, wp_ff, nxt_wp;
   logic [CNT_W-1:0]       cnt_ff, nxt_cnt;
   logic                   hv_ff, nxt_hv;
   logic [DATA_W+FL_W-1:0] hold_ff, nxt_hold;
   logic                   do_pop, full;

   assign full          = (cnt_ff == RX_FULL_CNT);
   assign do_pop        = pop && (cnt_ff != '0);
   assign head_data     = mem_ff[rp_ff][DATA_W+FL_W-1:FL_W];
   assign head_flags    = mem_ff[rp_ff][FL_W-1:0];
   assign count         = cnt_ff;
   assign hold_vld      = hv_ff;
   // New character with FIFO full and one already held: held one is lost
   assign overrun       = push && full && hv_ff && !do_pop;
   assign entered_flags = hv_ff && do_pop ? hold_ff[FL_W-1:0] : push_flags;

   // Next state of pointers, holding stage and storage
   always_comb
   begin
      nxt_mem  = mem_ff;
      nxt_rp   = rp_ff;
      nxt_wp   = wp_ff;
      nxt_cnt  = cnt_ff;
      nxt_hv   = hv_ff;
      nxt_hold = hold_ff;
      entered  = 1'b0;
      if (clr_flags)
      begin
         for (int i = 0; i < RX_DEPTH; i++)
            nxt_mem[i][FL_W-1:0] = '0;
         nxt_hold[FL_W-1:0] = '0;
      end
      if (do_pop)
      begin
         nxt_rp  = rp_ff + 3'h1;
         nxt_cnt = cnt_ff - 4'h1;
      end
      if (do_pop && hv_ff)
      begin
         // Held character takes the freed place, so full stays set
         nxt_mem[wp_ff] = hold_ff;
         nxt_wp  = wp_ff + 3'h1;
         nxt_cnt = cnt_ff;
         nxt_hv  = 1'b0;
         entered = 1'b1;
      end
      if (push)
      begin
         if (!full || (do_pop && !hv_ff))
         begin
            nxt_mem[wp_ff] = {push_data, push_flags};
            nxt_wp  = wp_ff + 3'h1;
            nxt_cnt = do_pop ? cnt_ff : cnt_ff + 4'h1;
            entered = 1'b1;
         end
         else
         begin
            // Replaces any held character with its flags
            nxt_hold = {push_data, push_flags};
            nxt_hv   = 1'b1;
         end
      end
      if (flush)
      begin
         nxt_rp  = '0;
         nxt_wp  = '0;
         nxt_cnt = '0;
         nxt_hv  = 1'b0;
         entered = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < RX_DEPTH; i++)
            mem_ff[i] <= '0;
         rp_ff   <= '0;
         wp_ff   <= '0;
         cnt_ff  <= '0;
         hv_ff   <= 1'b0;
         hold_ff <= '0;
      end
      else
      begin
         mem_ff  <= nxt_mem;
         rp_ff   <= nxt_rp;
         wp_ff   <= nxt_wp;
         cnt_ff  <= nxt_cnt;
         hv_ff   <= nxt_hv;
         hold_ff <= nxt_hold;
      end
   end
endmodule : ucs_rx_fifo

/* verif/ucs_station.sv */
/*
 * Remote station model: hands received characters to the status block
 * and drains its transmit side at a slow, steady pace.
 * Assumes the status block runs on the same core clock.
 */
`timescale 1ns/100ps
module ucs_station
   import ucs_pkg::*;
(
   // Clock
   input  wire logic              core_clk,
   // Receiver side
   output logic                   serial_rx_input,
   output logic                   bit_clk_en,
   output logic                   rx_char_done,
   output logic      [DATA_W-1:0] rx_char_data,
   output logic                   rx_stop_bit,
   output logic                   rx_parity_ok,
   output logic                   rx_ad_bit,
   // Transmitter side
   input  wire logic              tx_load_ff,
   output logic                   tx_char_moved,
   output logic                   tx_stop_sent
);
   logic [3:0] div_ff = 4'h0;
   int         loads  = 0;
   int         moves  = 0;
   initial
   begin
      {serial_rx_input, bit_clk_en, rx_char_done, rx_stop_bit} = 4'h9;
      {rx_parity_ok, rx_ad_bit, tx_char_moved, tx_stop_sent} = 4'h0;
      rx_char_data = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////
   // Free-running 1x rate, one pulse every sixteen cycles
   always @(posedge core_clk)
   begin
      div_ff     <= div_ff + 4'h1;
      bit_clk_en <= (div_ff == 4'hf);
      if (tx_load_ff === 1'b1) loads <= loads + 1;
   end
   // Slow drain so the transmit FIFO can be seen full
   initial forever
   begin
      @(posedge core_clk);
      if (loads > moves)
      begin
         repeat (40) @(posedge core_clk);
         tx_char_moved <= 1'b1;
         @(posedge core_clk);
         tx_char_moved <= 1'b0;
         moves++;
         repeat (40) @(posedge core_clk);
         tx_stop_sent <= 1'b1;
         @(posedge core_clk);
         tx_stop_sent <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Line level, low while a break is being sent
   task line(input logic v);
      @(posedge core_clk);
      serial_rx_input <= v;
   endtask : line
   // One received character; data and stop bit carry junk outside the strobe
   task send_char(input logic [7:0] d, input logic stop, input logic par, input logic ad);
      @(posedge core_clk);
      rx_char_done <= 1'b1;
      rx_char_data <= d;
      rx_stop_bit  <= stop;
      rx_parity_ok <= par;
      rx_ad_bit    <= ad;
      @(posedge core_clk);
      rx_char_done <= 1'b0;
      rx_char_data <= ~d;
      rx_stop_bit  <= ~stop;
   endtask : send_char
endmodule : ucs_station

/* verif/test_ucs_status.sv */
/*
 * Testbench for the line-status block: APB register calls plus station events.
 * Assumes one 40 MHz clock and the station model beside the design.
 */
`timescale 1ns/100ps
module test_ucs_status
   import ucs_pkg::*;
;
   logic core_clk, arst_n, psel, penable, pwrite, pready_ff, pslverr_ff, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata_ff, rd;
   logic srx, bce, rcd, rsb, rpo, rad, tcm, tss, tld, tact, bchg;
   logic [7:0] rcdat, tdat;
   int mismatches, checked, cycles, brk, i;
   ucs_status ucs_status_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
      .pslverr_ff(pslverr_ff), .serial_rx_input(srx), .bit_clk_en(bce), .rx_char_done(rcd),
      .rx_char_data(rcdat), .rx_stop_bit(rsb), .rx_parity_ok(rpo), .rx_ad_bit(rad), .tx_char_moved(tcm),
      .tx_stop_sent(tss), .tx_load_ff(tld), .tx_data_ff(tdat), .tx_active_ff(tact), .break_change_ff(bchg));
   ucs_station ucs_station_inst (.core_clk(core_clk), .serial_rx_input(srx), .bit_clk_en(bce),
      .rx_char_done(rcd), .rx_char_data(rcdat), .rx_stop_bit(rsb), .rx_parity_ok(rpo), .rx_ad_bit(rad),
      .tx_load_ff(tld), .tx_char_moved(tcm), .tx_stop_sent(tss));
   ////////////////////////////////////////////////////////////////////
   // Clock, break-event count and hang guard
   initial forever #12.5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (bchg === 1'b1) brk <= brk + 1;
      if (cycles == 6000)
      begin
         mismatches++;
         $display("unexpected at %0t: run timed out", $time);
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////
   // One APB transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      // Ends when pready is high; without it only the bench's cycle ceiling ends this wait
      do @(posedge core_clk); while (pready_ff !== 1'b1);
      rd  = prdata_ff;
      err = pslverr_ff;
      {psel, penable} <= 2'h0;
   endtask : apb
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // Status read compared under a mask
   task st(input logic [7:0] exp, input logic [7:0] m);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd & {24'h0, m}, {24'h0, exp}, "status");
   endtask : st
   task report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {core_clk, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {mismatches, checked, cycles, brk} = '0;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      st(8'h00, 8'hff);
      apb(1'b1, 8'h08, 32'h1);
      st(8'h0c, 8'hff);
      for (i = 0; i < 8; i++) apb(1'b1, 8'h00, i);
      st(8'h00, 8'h0c);
      chk(tdat, 32'h7, "tx data");
      repeat (800) @(posedge core_clk);
      st(8'h0c, 8'h0c);
      ucs_station_inst.send_char(8'h55, 1'b0, 1'b1, 1'b0);
      st(8'h41, 8'he1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h55, "data");
      st(8'h00, 8'he1);
      apb(1'b1, 8'h08, 32'h5);
      ucs_station_inst.send_char(8'h56, 1'b1, 1'b0, 1'b0);
      st(8'h21, 8'he1);
      apb(1'b0, 8'h00, 32'h0);
      apb(1'b1, 8'h08, 32'h9);
      ucs_station_inst.send_char(8'h57, 1'b1, 1'b1, 1'b1);
      st(8'h21, 8'he1);
      apb(1'b0, 8'h00, 32'h0);
      apb(1'b1, 8'h08, 32'h1);
      // Break in character mode: a second character is shut out
      ucs_station_inst.line(1'b0);
      ucs_station_inst.send_char(8'h00, 1'b0, 1'b1, 1'b0);
      st(8'h81, 8'h81);
      ucs_station_inst.send_char(8'h33, 1'b1, 1'b1, 1'b0);
      apb(1'b0, 8'h00, 32'h0);
      st(8'h00, 8'h81);
      ucs_station_inst.line(1'b1);
      repeat (60) @(posedge core_clk);
      chk(brk, 2, "break events");
      // Overrun: the held character is replaced by the newest
      for (i = 0; i < 10; i++) ucs_station_inst.send_char(i, 1'b1, 1'b1, 1'b0);
      st(8'h13, 8'h13);
      for (i = 0; i < 9; i++)
      begin
         apb(1'b0, 8'h00, 32'h0);
         chk(rd, (i == 8) ? 9 : i, "rx data");
         if (i == 0) st(8'h13, 8'h13);
      end
      apb(1'b1, 8'h0c, 32'h2);
      st(8'h10, 8'h13);
      apb(1'b1, 8'h0c, 32'h4);
      st(8'h00, 8'h13);
      // Block mode keeps the flags until the error reset
      apb(1'b1, 8'h08, 32'h3);
      ucs_station_inst.line(1'b0);
      ucs_station_inst.send_char(8'h00, 1'b0, 1'b1, 1'b0);
      apb(1'b0, 8'h00, 32'h0);
      st(8'hc0, 8'hc1);
      apb(1'b1, 8'h0c, 32'h4);
      st(8'h00, 8'hc1);
      ucs_station_inst.line(1'b1);
      repeat (60) @(posedge core_clk);
      chk(brk, 4, "break events");
      apb(1'b1, 8'h08, 32'h0);
      st(8'h00, 8'h0c);
      chk(tact, 1'b0, "tx disabled");
      apb(1'b1, 8'h08, 32'h1);
      st(8'h0c, 8'h0c);
      // Transmitter reset drops a waiting load; still enabled, so it re-arms
      apb(1'b1, 8'h00, 32'h5a);
      apb(1'b1, 8'h0c, 32'h3);
      st(8'h0c, 8'h0c);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1, "unmapped");
      report_and_stop();
   end
endmodule : test_ucs_status
